// ---- bench/nsr_checker.sv ----
// assertions on the executor ports
`timescale 1ns/100ps
`default_nettype none
module nsr_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic device_reset,
  // watched ports
  input wire logic [15:0] instr,
  input wire logic instr_valid,
  input wire logic busy,
  input wire logic [7:0] mem_rdata,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_we,
  input wire logic [20:0] pc,
  input wire logic [7:0] working,
  input wire logic [4:0] flags
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst || device_reset);
  // busy cycle refuses, so it never counts as taken
  wire go = instr_valid && !busy;
  wire neg = go && instr[15:9] == 7'h36;
  wire cal = go && instr[15:11] == 5'h1b;
  wire lit = go && instr[15:8] == 8'h0c;
  wire pop = go && instr == 16'h0006;
  wire [20:0] offs = {{9{instr[10]}}, instr[10:0], 1'b0};
  sequence s_idle;
    busy ##1 !busy;
  endsequence
  a_neg_result: assert property (
    neg |=> mem_we && mem_wdata == ~$past(mem_rdata) + 8'h01)
    else $error("negate value");
  a_neg_zero: assert property (
    neg |=> flags[2] == ($past(mem_rdata) == 8'h00))
    else $error("negate zero");
  a_neg_ovf: assert property (
    neg |=> flags[3] == ($past(mem_rdata) == 8'h80))
    else $error("negate overflow");
  a_neg_pc: assert property (
    neg |=> pc == $past(pc) + 21'h2 && !busy)
    else $error("negate length");
  a_pop_flags: assert property (
    pop |=> $stable(flags))
    else $error("pop flags");
  a_call_pc: assert property (
    cal |=> pc == $past(pc) + 21'h2 + $past(offs))
    else $error("call target");
  a_call_idle: assert property (
    cal |=> s_idle)
    else $error("call idle");
  a_lit_w: assert property (
    lit |=> working == $past(instr[7:0]) ##1 !busy)
    else $error("literal return");
endmodule
`default_nettype wire

// ---- bench/prog_mem.sv ----
// program memory model feeding words by pc
`timescale 1ns/100ps
`default_nettype none
module prog_mem (
  // fetch
  input wire logic [20:0] pc,
  output logic [15:0] instr
);
  logic [15:0] mem [0:15];
  // small window: pc wraps onto 16 words
  assign instr = mem[pc[4:1]];
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
  end
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// self-checking bench for the executor
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk = 0;
  logic rst = 1;
  logic instr_valid = 0;
  logic shadow_load = 0;
  logic priority_mode = 1;
  logic clr = 0;
  logic [7:0] mem_rdata = 8'h00;
  logic [7:0] shadow_w_in = 8'h00;
  logic [4:0] shadow_st_in = 5'h00;
  logic [3:0] shadow_bank_in = 4'h0;
  wire [15:0] instr;
  wire [11:0] mem_addr;
  wire [7:0] mem_wdata, working, pc_high_latch;
  wire [20:0] pc;
  wire [4:0] flags, pc_upper_latch;
  wire [3:0] bank_select_reg;
  wire mem_we, busy, device_reset, gie_h, gie_l;
  wire stk_full, stk_empty;
  int num_errors = 0;
  int n_tests = 0;
  prog_mem pm (.pc, .instr);
  negate_stack_return_ops uut (.clk, .rst(rst), .instr, .instr_valid,
    .mem_rdata, .mem_addr, .mem_wdata, .mem_we, .pc, .working, .flags,
    .bank_select_reg, .pc_high_latch, .pc_upper_latch, .shadow_load,
    .shadow_w_in, .shadow_st_in, .shadow_bank_in, .priority_mode,
    .enable_clear_high(clr), .enable_clear_low(clr),
    .high_prio_global_enable(gie_h), .low_prio_global_enable(gie_l),
    .busy, .device_reset, .stack_full_err(stk_full),
    .stack_empty_err(stk_empty));
  always #10 clk = ~clk;
  task chk(string s, logic [20:0] e, logic [20:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  // one word, then let the taken edge land
  task exec(logic [15:0] w, logic [7:0] rd = 8'h00, logic c = 1'b0);
    @(posedge clk);
    pm.mem[pc[4:1]] <= w;
    mem_rdata <= rd;
    clr <= c;
    instr_valid <= 1;
    @(posedge clk);
    instr_valid <= 0;
    clr <= 0;
    #1;
  endtask
  task t_call_ret;
    shadow_w_in <= 8'h5a;
    shadow_st_in <= 5'h15;
    shadow_bank_in <= 4'h5;
    shadow_load <= 1;
    @(posedge clk);
    shadow_load <= 0;
    exec(16'hdffd);
    chk("pc", 21'h1ffffc, pc);
    exec(16'h0011);
    chk("pc", 21'h2, pc);
    chk("w", 8'h5a, working);
    chk("bank", 4'h5, bank_select_reg);
    chk("flags", 5'h15, flags);
    chk("gie_h", 1, gie_h);
    exec(16'hdbff);
    chk("pc", 21'h802, pc);
    exec(16'h0ca5);
    chk("pc", 21'h4, pc);
    chk("w", 8'ha5, working);
    chk("latch", 0, {pc_upper_latch, pc_high_latch});
  endtask
  task t_stack;
    logic [4:0] f0;
    exec(16'h0005);
    exec(16'h0005);
    chk("pc", 21'h8, pc);
    f0 = flags;
    exec(16'h0006);
    chk("flags", f0, flags);
    @(posedge clk);
    priority_mode <= 0;
    exec(16'h0010, 8'h00, 1'b1);
    chk("pc", 21'h6, pc);
    chk("gie_l", 1, gie_l);
    chk("gie_h", 0, gie_h);
    chk("w", 8'ha5, working);
  endtask
  task neg(logic a, logic [7:0] f, logic [7:0] v, logic [11:0] ea);
    logic [7:0] r;
    r = ~v + 8'h01;
    exec({7'h36, a, f}, v);
    chk("wdata", r, mem_wdata);
    chk("we", 1, mem_we);
    chk("addr", ea, mem_addr);
    chk("flags", {r[7], v == 8'h80, r == 8'h00, v[3:0] == 4'h0,
      v == 8'h00}, flags);
  endtask
  task t_depth;
    exec(16'h0006);
    @(posedge clk);
    #1;
    chk("empty", 1, stk_empty);
    repeat (31) exec(16'h0005);
    @(posedge clk);
    #1;
    chk("full", 0, stk_full);
    exec(16'h0005);
    @(posedge clk);
    #1;
    chk("full", 1, stk_full);
  endtask
  task t_reset;
    int i;
    exec(16'h00ff);
    for (i = 0; i < 9 && device_reset !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk("dev_rst", 1, device_reset);
    for (i = 0; i < 9 && device_reset !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    chk("pc", 0, pc);
    chk("w", 0, working);
    chk("flags", 0, flags);
    chk("gie", 0, {gie_h, gie_l});
    chk("stk_err", 0, {stk_full, stk_empty});
    exec(16'h0005);
    chk("pc", 21'h2, pc);
  endtask
  task final_report;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    t_call_ret;
    t_stack;
    neg(1'b1, 8'h12, 8'h3a, 12'h512);
    neg(1'b0, 8'h90, 8'h80, 12'hf90);
    neg(1'b0, 8'h7f, 8'h00, 12'h07f);
    t_depth;
    t_reset;
    final_report;
  end
  // run needs about 100 cycles
  initial begin
    repeat (2000) @(posedge clk);
    num_errors++;
    final_report;
  end
endmodule
bind negate_stack_return_ops nsr_checker chk_i (.clk, .rst, .device_reset,
  .instr,
  .instr_valid, .busy, .mem_rdata, .mem_wdata, .mem_we, .pc, .working,
  .flags);
`default_nettype wire

// ---- verilog/negate_alu.v ----
// two's complement negate with flag results
`timescale 1ns/100ps
`default_nettype none
module negate_alu (
  // operand
  input wire [7:0] operand,
  // result
  output wire [7:0] result,
  output wire [4:0] flags
);
  // ****************************************
  // 0 - f with carry meaning no borrow
  // ****************************************
  wire [8:0] sum = {1'b0, ~operand} + 9'h001;
  wire [4:0] lo = {1'b0, ~operand[3:0]} + 5'h01;
  assign result = sum[7:0];
  assign flags = {sum[7], operand[7] & sum[7], result == 8'h00,
    lo[4], sum[8]};
endmodule
`default_nettype wire

// ---- verilog/negate_stack_return_ops.v ----
// executor for negate, stack, relative call, reset and return instructions
`include "stack_ops_defines.vh"
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// RL1 - negate writes inverse plus one back
// RL2 - negate sets n ov c dc z flags
// RL3 - bank bit zero selects access bank
// RL4 - pop discards top entry, flags kept
// RL5 - after pop, older entry becomes top
// RL6 - push stores pc plus two on top
// RL7 - relative call pushes pc plus two
// RL8 - call jumps pc+2+2n, two cycles
// RL9 - reset instruction restores reset values
// RL10 - interrupt return pops pc, sets enable
// RL11 - shadow bit restores w status bank
// RL12 - literal return loads w, pops pc
// RL13 - returns keep pc latch registers
// RL14 - stack depth 31, overflow sticky, underflow zero
module negate_stack_return_ops #(
  parameter DEPTH = `STK_DEPTH,
  parameter PTR_W = `STK_PTR_W
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // instruction fetch
  input wire [15:0] instr,
  input wire instr_valid,
  // data memory read and write port
  input wire [7:0] mem_rdata,
  output reg [11:0] mem_addr,
  output reg [7:0] mem_wdata,
  output reg mem_we,
  // core register state
  output reg [`PC_W-1:0] pc,
  output reg [7:0] working,
  output reg [4:0] flags,
  output reg [3:0] bank_select_reg,
  output reg [7:0] pc_high_latch,
  output reg [4:0] pc_upper_latch,
  // shadow copies loaded by interrupt entry
  input wire shadow_load,
  input wire [7:0] shadow_w_in,
  input wire [4:0] shadow_st_in,
  input wire [3:0] shadow_bank_in,
  // interrupt enables
  input wire priority_mode,
  input wire enable_clear_high,
  input wire enable_clear_low,
  output reg high_prio_global_enable,
  output reg low_prio_global_enable,
  // status
  output reg busy,
  output reg device_reset,
  output reg stack_full_err,
  output reg stack_empty_err
);
  // ****************************************
  // states and decode
  // ****************************************
  localparam S_RUN = 3'b001;
  localparam S_IDLE2 = 3'b010;
  localparam S_RST = 3'b100;
  reg [2:0] state;
  reg [7:0] rst_cnt;
  reg [7:0] working_shadow;
  reg [4:0] flags_shadow;
  reg [3:0] bank_shadow;
  // the reset pulse also blocks execution, else a negate could still write
  wire go = instr_valid && (state == S_RUN) && !device_reset;
  wire negate_file_op = go && instr[15:9] == `OPC_NEGATE_HI; // [RL1]
  wire pop_op = go && instr == `OPC_POP;
  wire push_op = go && instr == `OPC_PUSH;
  wire relative_call_op = go && instr[15:11] == `OPC_REL_CALL_HI;
  wire reset_op = go && instr == `OPC_RESET;
  wire interrupt_return_op = go && instr[15:1] == `OPC_INT_RET_HI;
  wire literal_return_op = go && instr[15:8] == `OPC_LIT_RET_HI;
  wire any_ret = interrupt_return_op | literal_return_op;
  wire [`PC_W-1:0] pc_plus2 = pc + 21'h000002;
  // sign extended word offset doubled to bytes
  wire [`PC_W-1:0] rel_off = {{9{instr[10]}}, instr[10:0], 1'b0};
  wire [7:0] neg_result;
  wire [4:0] neg_flags;
  wire [`PC_W-1:0] top;
  wire [PTR_W-1:0] used;
  wire ovf;
  wire unf;
  wire [11:0] next_addr = instr[8] ? {bank_select_reg, instr[7:0]} :
    {{4{instr[7]}}, instr[7:0]}; // [RL3]
  // ****************************************
  // submodules
  // ****************************************
  negate_alu u_alu (
    .operand(mem_rdata),
    .result(neg_result),
    .flags(neg_flags)
  );
  return_stack #(
    .DEPTH(DEPTH),
    .PTR_W(PTR_W),
    .DATA_W(`PC_W)
  ) u_stack (
    .clk(clk),
    .rst(rst | device_reset),
    .push(push_op | relative_call_op), // [RL6] [RL7]
    .pop(pop_op | any_ret), // [RL4] [RL5]
    .push_data(pc_plus2),
    .stack_top_entry(top),
    .depth_used(used),
    .overflow(ovf),
    .underflow(unf)
  );
  // ****************************************
  // data memory address, combinational read
  // ****************************************
  // operand address is presented straight from the instruction word so
  // the read data arrive in the same cycle; mem_addr copies it for trace
  always @(posedge clk) begin
    if (rst) begin
      mem_addr <= 12'h000;
      mem_wdata <= `RESET_BYTE;
      mem_we <= 1'b0;
    end else begin
      mem_addr <= next_addr;
      mem_we <= negate_file_op; // [RL1]
      mem_wdata <= neg_result; // [RL1]
    end
  end
  // ****************************************
  // core state
  // ****************************************
  always @(posedge clk) begin
    if (rst || device_reset) begin
      // back to run so the core resumes once the pulse ends [RL9]
      state <= S_RUN;
      pc <= `RESET_PC;
      working <= `RESET_BYTE;
      flags <= `RESET_FLAGS;
      bank_select_reg <= 4'h0;
      pc_high_latch <= `RESET_BYTE;
      pc_upper_latch <= 5'h00;
      working_shadow <= `RESET_BYTE;
      flags_shadow <= `RESET_FLAGS;
      bank_shadow <= 4'h0;
      high_prio_global_enable <= 1'b0;
      low_prio_global_enable <= 1'b0;
      busy <= 1'b0;
    end else begin
      busy <= 1'b0;
      if (shadow_load) begin
        working_shadow <= shadow_w_in;
        flags_shadow <= shadow_st_in;
        bank_shadow <= shadow_bank_in;
      end
      if (enable_clear_high) begin
        high_prio_global_enable <= 1'b0;
      end
      if (enable_clear_low) begin
        low_prio_global_enable <= 1'b0;
      end
      case (state)
        S_RUN: begin
          if (go) begin
            pc <= pc_plus2;
          end
          if (negate_file_op) begin
            flags <= neg_flags; // [RL2]
          end
          if (relative_call_op) begin
            pc <= pc_plus2 + rel_off; // [RL8]
            state <= S_IDLE2;
            busy <= 1'b1;
          end
          if (any_ret) begin
            // latches untouched, pc reloads from the stack top [RL13]
            pc <= top;
            state <= S_IDLE2;
            busy <= 1'b1;
          end
          if (literal_return_op) begin
            working <= instr[7:0]; // [RL12]
          end
          if (interrupt_return_op) begin
            // set wins over a clear in the same cycle [RL10]
            if (priority_mode) begin
              high_prio_global_enable <= 1'b1;
            end else begin
              low_prio_global_enable <= 1'b1;
            end
            if (instr[0]) begin
              working <= working_shadow; // [RL11]
              flags <= flags_shadow;
              bank_select_reg <= bank_shadow;
            end
          end
          if (reset_op) begin
            state <= S_RST; // [RL9]
            busy <= 1'b1;
          end
        end
        S_IDLE2: begin
          state <= S_RUN; // second cycle idle [RL8] [RL10] [RL12]
        end
        S_RST: begin
          busy <= 1'b1;
        end
        default: begin
          state <= S_RUN;
        end
      endcase
    end
  end
  // ****************************************
  // software reset pulse
  // ****************************************
  always @(posedge clk) begin
    if (rst) begin
      device_reset <= 1'b0;
      rst_cnt <= 8'h00;
    end else if (reset_op) begin
      device_reset <= 1'b1; // [RL9]
      rst_cnt <= `RESET_CYCLES;
    end else if (rst_cnt != 8'h00) begin
      rst_cnt <= rst_cnt - 8'h01;
      device_reset <= (rst_cnt != 8'h01);
    end else begin
      device_reset <= 1'b0;
    end
  end
  // ****************************************
  // stack error status, registered copy of the sticky stack flags
  // ****************************************
  always @(posedge clk) begin
    if (rst) begin
      stack_full_err <= 1'b0;
      stack_empty_err <= 1'b0;
    end else begin
      stack_full_err <= ovf; // [RL14]
      stack_empty_err <= unf; // [RL14]
    end
  end
endmodule
`default_nettype wire

// ---- verilog/return_stack.v ----
// hardware return stack with registered top entry
`timescale 1ns/100ps
`default_nettype none
module return_stack #(
  parameter DEPTH = 31,
  parameter PTR_W = 5,
  parameter DATA_W = 21
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // stack control
  input wire push,
  input wire pop,
  input wire [DATA_W-1:0] push_data,
  // state
  output reg [DATA_W-1:0] stack_top_entry,
  output reg [PTR_W-1:0] depth_used,
  output reg overflow,
  output reg underflow
);
  // ****************************************
  // storage
  // ****************************************
  localparam [PTR_W-1:0] FULL_AT = DEPTH;
  reg [DATA_W-1:0] mem [0:DEPTH-1];
  wire [PTR_W-1:0] below = depth_used - {{(PTR_W-1){1'b0}}, 1'b1};
  wire [PTR_W-1:0] below2 = depth_used - {{(PTR_W-2){1'b0}}, 2'b10};
  wire full = (depth_used == FULL_AT);
  wire empty = (depth_used == {PTR_W{1'b0}});
  always @(posedge clk) begin
    if (rst) begin
      depth_used <= {PTR_W{1'b0}};
      stack_top_entry <= {DATA_W{1'b0}};
      overflow <= 1'b0;
      underflow <= 1'b0;
    end else if (push) begin
      // overflow drops the push, sticky flag until reset
      if (full) begin
        overflow <= 1'b1;
      end else begin
        mem[depth_used] <= push_data;
        stack_top_entry <= push_data;
        depth_used <= depth_used + {{(PTR_W-1){1'b0}}, 1'b1};
      end
    end else if (pop) begin
      if (empty) begin
        underflow <= 1'b1;
        stack_top_entry <= {DATA_W{1'b0}};
      end else begin
        depth_used <= below;
        stack_top_entry <= (depth_used > {{(PTR_W-2){1'b0}}, 2'b01}) ?
          mem[below2] : {DATA_W{1'b0}};
      end
    end
  end
endmodule
`default_nettype wire

// ---- verilog/stack_ops_defines.vh ----
// constants for the negate, stack and return instruction executor
`ifndef STACK_OPS_DEFINES_VH
`define STACK_OPS_DEFINES_VH
`define OPC_NEGATE_HI 7'h36
`define OPC_POP 16'h0006
`define OPC_PUSH 16'h0005
`define OPC_REL_CALL_HI 5'h1b
`define OPC_RESET 16'h00ff
`define OPC_INT_RET_HI 15'h0008
`define OPC_LIT_RET_HI 8'h0c
`define STK_DEPTH 31
`define STK_PTR_W 5
`define PC_W 21
`define ST_N 4
`define ST_OVF 3
`define ST_Z 2
`define ST_DCF 1
`define ST_C 0
`define RESET_PC 21'h000000
`define RESET_BYTE 8'h00
`define RESET_FLAGS 5'h00
`define RESET_CYCLES 8'h02
`endif
